// ==== common/tgd_pkg.sv ====
// constants for the time-out, time-guard and transfer-channel register block
// assumes a 20 MHz clock and a bit-period pulse from the baud generator
package tgd_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_RX_IDLE_LIMIT = 8'h00;
    localparam logic [7:0] OFF_TX_GAP = 8'h04;
    localparam logic [7:0] OFF_RX_BUF_ADDR = 8'h08;
    localparam logic [7:0] OFF_RX_BUF_COUNT = 8'h0C;
    localparam logic [7:0] OFF_TX_BUF_ADDR = 8'h10;
    localparam logic [7:0] OFF_TX_BUF_COUNT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h1C;
    // field layouts
    localparam int LIMIT_W = 8;
    localparam int COUNT_W = 16;
    localparam int ADDR_W = 32;
    localparam int PRE_W = 2;
    // time-out counts in groups of four bit periods
    localparam logic [PRE_W-1:0] PRE_LAST = 2'h3;
    // status bit positions
    localparam int ST_TIMEOUT = 0;
    localparam int ST_RX_AVAIL = 1;
    localparam int ST_TX_FREE = 2;
    localparam int ST_GUARD = 3;
    localparam int ST_RX_ACTIVE = 4;
    localparam int ST_TX_ACTIVE = 5;
    // control bit positions
    localparam int CT_START_TO = 0;
    // reset values
    localparam logic [LIMIT_W-1:0] LIMIT_RST = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    // guard sequencer states
    typedef enum logic [1:0] {
        GD_IDLE = 2'b01,
        GD_HOLD = 2'b10
    } guard_e;
endpackage : tgd_pkg

// ==== rtl/xfer_channel.sv ====
// one peripheral data transfer channel: address and count with auto advance
// assumes the transfer engine acknowledges each moved character with done
`timescale 1ns/1ps
module xfer_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // software load
    input wire logic addr_wr,
    input wire logic count_wr,
    input wire logic [31:0] wdata,
    // transfer handshake
    input wire logic cond,
    input wire logic done,
    output logic req,
    // state
    output logic [tgd_pkg::ADDR_W-1:0] addr,
    output logic [tgd_pkg::COUNT_W-1:0] count
);
    typedef struct packed {
        logic [tgd_pkg::ADDR_W-1:0] addr_r;
        logic [tgd_pkg::COUNT_W-1:0] count_r;
    } chan_s;
    chan_s st_r;
    chan_s st_nxt;

    // a write overrides the advance of the field it loads in the same cycle; software owns the pointer
    always_comb begin
        st_nxt = st_r;
        if (done && st_r.count_r != tgd_pkg::COUNT_RST) begin
            st_nxt.addr_r = st_r.addr_r + 32'h0000_0001;
            st_nxt.count_r = st_r.count_r - 16'h0001;
        end
        if (addr_wr) begin
            st_nxt.addr_r = wdata;
        end
        if (count_wr) begin
            st_nxt.count_r = wdata[tgd_pkg::COUNT_W-1:0];
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{tgd_pkg::ADDR_RST, tgd_pkg::COUNT_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // zero count halts, nonzero runs on the ready condition
    assign req = cond && (st_r.count_r != tgd_pkg::COUNT_RST);
    assign addr = st_r.addr_r;
    assign count = st_r.count_r;

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        (done && !addr_wr && !count_wr && count != 16'h0000)
        |=> count == $past(count) - 16'h0001 && addr == $past(addr) + 32'h1)
        else $error("channel did not advance by one");
    zero_halt_a: assert property (@(posedge clk) disable iff (rst)
        count == 16'h0000 |-> !req)
        else $error("channel requests with zero count");
endmodule : xfer_channel

// ==== rtl/tgd_regs.sv ====
// time-out, time-guard and transfer-channel registers of a serial port
// assumes bit_tick pulses once per bit period from the baud generator
`timescale 1ns/1ps
module tgd_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial core
    input wire logic bit_tick,
    input wire logic char_received,
    input wire logic rx_char_read,
    input wire logic holding_empty,
    input wire logic break_pending,
    input wire logic char_sent,
    input wire logic txd_core,
    output logic txd,
    output logic tx_hold_off,
    output logic rx_timeout,
    output logic rx_char_available,
    output logic tx_holding_free,
    // transfer engine
    input wire logic rx_xfer_done,
    input wire logic tx_xfer_done,
    output logic rx_xfer_req,
    output logic tx_xfer_req,
    output logic [31:0] rx_xfer_addr,
    output logic [31:0] tx_xfer_addr
);
    typedef struct packed {
        logic [tgd_pkg::LIMIT_W-1:0] rx_idle_limit;
        logic [tgd_pkg::LIMIT_W-1:0] tx_gap_length;
        logic [tgd_pkg::LIMIT_W-1:0] to_cnt_r;
        logic [tgd_pkg::PRE_W-1:0] pre_r;
        logic to_run_r;
        logic rx_started_r;
        logic timeout_r;
        logic avail_r;
        tgd_pkg::guard_e gd_r;
        logic [tgd_pkg::LIMIT_W-1:0] gd_cnt_r;
        logic [31:0] rdata_r;
    } regs_s;
    regs_s st_r;
    regs_s st_nxt;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic start_to;
    logic [tgd_pkg::COUNT_W-1:0] rx_count;
    logic [tgd_pkg::COUNT_W-1:0] tx_count;
    logic [5:0] status;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: zero wait states, unmapped offsets flag an error
    always_comb begin
        unique case (paddr)
            tgd_pkg::OFF_RX_IDLE_LIMIT, tgd_pkg::OFF_TX_GAP,
            tgd_pkg::OFF_RX_BUF_ADDR, tgd_pkg::OFF_RX_BUF_COUNT,
            tgd_pkg::OFF_TX_BUF_ADDR, tgd_pkg::OFF_TX_BUF_COUNT,
            tgd_pkg::OFF_STATUS, tgd_pkg::OFF_CONTROL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // start command from control word or any write to the limit register
    assign start_to = (wr_en && paddr == tgd_pkg::OFF_RX_IDLE_LIMIT)
        || (wr_en && paddr == tgd_pkg::OFF_CONTROL
            && pwdata[tgd_pkg::CT_START_TO]);

    ////////////////////////////////////////////////////////////////////////
    // channels
    xfer_channel rx_chan (
        .clk(clk),
        .rst(rst),
        .addr_wr(wr_en && paddr == tgd_pkg::OFF_RX_BUF_ADDR),
        .count_wr(wr_en && paddr == tgd_pkg::OFF_RX_BUF_COUNT),
        .wdata(pwdata),
        .cond(rx_char_available),
        .done(rx_xfer_done),
        .req(rx_xfer_req),
        .addr(rx_xfer_addr),
        .count(rx_count)
    );
    xfer_channel tx_chan (
        .clk(clk),
        .rst(rst),
        .addr_wr(wr_en && paddr == tgd_pkg::OFF_TX_BUF_ADDR),
        .count_wr(wr_en && paddr == tgd_pkg::OFF_TX_BUF_COUNT),
        .wdata(pwdata),
        .cond(tx_holding_free),
        .done(tx_xfer_done),
        .req(tx_xfer_req),
        .addr(tx_xfer_addr),
        .count(tx_count)
    );

    // status word seen by software
    assign status = {tx_xfer_req, rx_xfer_req, tx_hold_off,
        tx_holding_free, rx_char_available, rx_timeout};

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // register writes
        if (wr_en && paddr == tgd_pkg::OFF_RX_IDLE_LIMIT) begin
            st_nxt.rx_idle_limit = pwdata[tgd_pkg::LIMIT_W-1:0];
        end
        if (wr_en && paddr == tgd_pkg::OFF_TX_GAP) begin
            st_nxt.tx_gap_length = pwdata[tgd_pkg::LIMIT_W-1:0];
        end
        // character available: arrival wins over a read in the same cycle
        if (rx_char_read) begin
            st_nxt.avail_r = 1'b0;
        end
        if (char_received) begin
            st_nxt.avail_r = 1'b1;
        end
        // idle time-out: counts only after reception begins
        if (char_received) begin
            st_nxt.rx_started_r = 1'b1;
        end
        if (start_to) begin
            st_nxt.rx_started_r = 1'b0;
            st_nxt.timeout_r = 1'b0;
            st_nxt.to_cnt_r = (wr_en && paddr == tgd_pkg::OFF_RX_IDLE_LIMIT)
                ? pwdata[tgd_pkg::LIMIT_W-1:0] : st_r.rx_idle_limit;
            st_nxt.pre_r = '0;
            st_nxt.to_run_r = 1'b0;
        end else if (char_received) begin
            st_nxt.to_cnt_r = st_r.rx_idle_limit;
            st_nxt.pre_r = '0;
            st_nxt.to_run_r = st_r.rx_idle_limit != tgd_pkg::LIMIT_RST;
        end else if (st_r.to_run_r && bit_tick) begin
            st_nxt.pre_r = st_r.pre_r + 2'h1;
            if (st_r.pre_r == tgd_pkg::PRE_LAST) begin
                st_nxt.to_cnt_r = st_r.to_cnt_r - 8'h01;
                if (st_r.to_cnt_r == 8'h01) begin
                    st_nxt.to_run_r = 1'b0;
                    st_nxt.timeout_r = 1'b1;
                end
            end
        end
        // limit of zero keeps the function off
        if (st_nxt.rx_idle_limit == tgd_pkg::LIMIT_RST) begin
            st_nxt.to_run_r = 1'b0;
            st_nxt.timeout_r = 1'b0;
        end
        // guard gap after each sent character
        unique case (st_r.gd_r)
            tgd_pkg::GD_IDLE: begin
                if (char_sent && st_r.tx_gap_length != tgd_pkg::LIMIT_RST) begin
                    st_nxt.gd_r = tgd_pkg::GD_HOLD;
                    st_nxt.gd_cnt_r = st_r.tx_gap_length;
                end
            end
            tgd_pkg::GD_HOLD: begin
                if (bit_tick) begin
                    st_nxt.gd_cnt_r = st_r.gd_cnt_r - 8'h01;
                    if (st_r.gd_cnt_r == 8'h01) begin
                        st_nxt.gd_r = tgd_pkg::GD_IDLE;
                    end
                end
            end
            default: st_nxt.gd_r = tgd_pkg::GD_IDLE;
        endcase
        // read data captured in the setup phase
        if (rd_en) begin
            unique case (paddr)
                tgd_pkg::OFF_RX_IDLE_LIMIT:
                    st_nxt.rdata_r = {24'h000000, st_r.rx_idle_limit};
                tgd_pkg::OFF_TX_GAP:
                    st_nxt.rdata_r = {24'h000000, st_r.tx_gap_length};
                tgd_pkg::OFF_RX_BUF_ADDR: st_nxt.rdata_r = rx_xfer_addr;
                tgd_pkg::OFF_RX_BUF_COUNT: st_nxt.rdata_r = {16'h0000, rx_count};
                tgd_pkg::OFF_TX_BUF_ADDR: st_nxt.rdata_r = tx_xfer_addr;
                tgd_pkg::OFF_TX_BUF_COUNT: st_nxt.rdata_r = {16'h0000, tx_count};
                tgd_pkg::OFF_STATUS: st_nxt.rdata_r = {26'h0000000, status};
                default: st_nxt.rdata_r = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{tgd_pkg::LIMIT_RST, tgd_pkg::LIMIT_RST, tgd_pkg::LIMIT_RST,
                2'h0, 1'b0, 1'b0, 1'b0, 1'b0, tgd_pkg::GD_IDLE,
                tgd_pkg::LIMIT_RST, 32'h0000_0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = st_r.rdata_r;
    assign rx_timeout = st_r.timeout_r;
    assign rx_char_available = st_r.avail_r;
    // break waiting or full holding register means not free
    assign tx_holding_free = holding_empty && !break_pending;
    assign tx_hold_off = st_r.gd_r == tgd_pkg::GD_HOLD;
    // the line idles high during the gap, core is stalled by tx_hold_off
    assign txd = tx_hold_off ? 1'b1 : txd_core;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence limit_written_s;
        wr_en && paddr == tgd_pkg::OFF_RX_IDLE_LIMIT;
    endsequence
    sequence gap_started_s;
        !tx_hold_off && char_sent && st_r.tx_gap_length != 8'h00;
    endsequence

    limit_write_start_a: assert property (@(posedge clk) disable iff (rst)
        limit_written_s |=> !rx_timeout && st_r.to_cnt_r == $past(pwdata[7:0]))
        else $error("limit write did not restart time-out");
    zero_limit_off_a: assert property (@(posedge clk) disable iff (rst)
        st_r.rx_idle_limit == 8'h00 |-> !rx_timeout)
        else $error("time-out flagged with zero limit");
    char_reload_a: assert property (@(posedge clk) disable iff (rst)
        (char_received && !start_to) |=> st_r.to_cnt_r == $past(st_r.rx_idle_limit))
        else $error("counter not reloaded on character");
    one_unit_timeout_a: assert property (@(posedge clk) disable iff (rst)
        (st_r.to_run_r && st_r.to_cnt_r == 8'h01 && st_r.pre_r == 2'h3
         && bit_tick && !char_received && !start_to && !wr_en)
        |=> rx_timeout)
        else $error("time-out did not expire after four bits");
    flag_holds_a: assert property (@(posedge clk) disable iff (rst)
        (rx_timeout && !start_to && st_r.rx_idle_limit != 8'h00 && !wr_en)
        |=> rx_timeout)
        else $error("time-out flag dropped early");
    avail_set_a: assert property (@(posedge clk) disable iff (rst)
        char_received |=> rx_char_available)
        else $error("arrival lost");
    free_cond_a: assert property (@(posedge clk) disable iff (rst)
        tx_holding_free |-> holding_empty && !break_pending)
        else $error("free while holding full or break");
    no_gap_a: assert property (@(posedge clk) disable iff (rst)
        (char_sent && !tx_hold_off && st_r.tx_gap_length == 8'h00) |=> !tx_hold_off)
        else $error("gap inserted with zero length");
    gap_high_a: assert property (@(posedge clk) disable iff (rst)
        gap_started_s |=> tx_hold_off && txd)
        else $error("line not held high after character");
    gap_len_a: assert property (@(posedge clk) disable iff (rst)
        (tx_hold_off && st_r.gd_cnt_r == 8'h01 && bit_tick) |=> !tx_hold_off)
        else $error("gap length wrong");
    rx_run_a: assert property (@(posedge clk) disable iff (rst)
        (rx_char_available && rx_count != 16'h0000) |-> rx_xfer_req)
        else $error("receive channel idle with work");
    tx_run_a: assert property (@(posedge clk) disable iff (rst)
        (tx_xfer_req) |-> tx_holding_free && tx_count != 16'h0000)
        else $error("transmit channel moved wrongly");
endmodule : tgd_regs

// ==== test/serial_side_model.sv ====
// far-side model of the serial core: bit timing and character events
// assumes one bench process calls its tasks just after rising clock edges
`timescale 1ns/1ps
module serial_side_model #(
    parameter int BIT_CLKS = 8
) (
    // clock
    input wire logic clk,
    // guard status seen by the core
    input wire logic tx_hold_off,
    // core events towards the block
    output logic bit_tick,
    output logic char_received,
    output logic char_sent,
    output logic txd_core
);
    ////////////////////////////////////////////////////////////////////////
    // line idles high, every event is a one-clock pulse
    initial begin
        bit_tick = 1'b0;
        char_received = 1'b0;
        char_sent = 1'b0;
        txd_core = 1'b1;
    end

    // n bit periods, tick at the end of each
    task automatic ticks(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CLKS - 1) @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask : ticks

    // trailing edge keeps a following call from reassigning in one step
    task automatic rx_char();
        char_received <= 1'b1;
        @(posedge clk);
        char_received <= 1'b0;
        @(posedge clk);
    endtask : rx_char

    // start bit, stop bit, then the finished pulse; waits out any guard
    task automatic tx_char();
        while (tx_hold_off) @(posedge clk);
        txd_core <= 1'b0;
        ticks(1);
        txd_core <= 1'b1;
        ticks(1);
        char_sent <= 1'b1;
        @(posedge clk);
        char_sent <= 1'b0;
        @(posedge clk);
    endtask : tx_char
endmodule : serial_side_model

// ==== test/usart_timeout_guard_dma_regs_tb.sv ====
// self-checking bench for the time-out, guard and channel registers
// assumes tgd_regs answers apb with pready and the model sets bit timing
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    comparisons++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("unexpected %s: expected %0h seen %0h", nm, exp, got); \
    end
module usart_timeout_guard_dma_regs_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, rx_xfer_addr, tx_xfer_addr;
    logic bit_tick, char_received, rx_char_read, holding_empty;
    logic break_pending, char_sent, txd_core, txd, tx_hold_off, rx_timeout;
    logic rx_char_available, tx_holding_free, rx_xfer_done, tx_xfer_done;
    logic rx_xfer_req, tx_xfer_req, er;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    tgd_regs dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_tick(bit_tick),
        .char_received(char_received), .rx_char_read(rx_char_read),
        .holding_empty(holding_empty), .break_pending(break_pending),
        .char_sent(char_sent), .txd_core(txd_core), .txd(txd),
        .tx_hold_off(tx_hold_off), .rx_timeout(rx_timeout),
        .rx_char_available(rx_char_available),
        .tx_holding_free(tx_holding_free), .rx_xfer_done(rx_xfer_done),
        .tx_xfer_done(tx_xfer_done), .rx_xfer_req(rx_xfer_req),
        .tx_xfer_req(tx_xfer_req), .rx_xfer_addr(rx_xfer_addr),
        .tx_xfer_addr(tx_xfer_addr));
    serial_side_model #(.BIT_CLKS(8)) model_u (.clk(clk),
        .tx_hold_off(tx_hold_off), .bit_tick(bit_tick),
        .char_received(char_received), .char_sent(char_sent),
        .txd_core(txd_core));

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock; a hang ends the run well past the expected length
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // apb master: setup, access until pready, release and one idle edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr_rd(input logic [7:0] a, input logic [31:0] w, x);
        apb(1'b1, a, w);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("read back", x, rd)
        `CHK("slave error", 1'b0, er)
    endtask : wr_rd

    // one-clock pulse of the transfer engine or of a register read
    task automatic pulse(input int which);
        case (which)
            0: rx_xfer_done <= 1'b1;
            1: tx_xfer_done <= 1'b1;
            default: rx_char_read <= 1'b1;
        endcase
        @(posedge clk);
        {rx_xfer_done, tx_xfer_done, rx_char_read} <= 3'h0;
        @(posedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, psel, penable, pwrite, rx_char_read, break_pending} = 6'h00;
        {rx_xfer_done, tx_xfer_done, paddr, pwdata} = 42'h0;
        {rst, holding_empty} = 2'h3;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values, then an unmapped word
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            `CHK("reset value", 32'h0000_0000, rd)
        end
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK("unmapped data", 32'h0000_0000, rd)
        `CHK("unmapped error", 1'b1, er)
        wr_rd(tgd_pkg::OFF_RX_IDLE_LIMIT, 32'hFFFF_FF5A, 32'h0000_005A);
        wr_rd(tgd_pkg::OFF_TX_GAP, 32'hFFFF_FF3C, 32'h0000_003C);
        wr_rd(tgd_pkg::OFF_RX_BUF_ADDR, 32'h8765_4321, 32'h8765_4321);
        wr_rd(tgd_pkg::OFF_RX_BUF_COUNT, 32'hFFFF_1234, 32'h0000_1234);
        wr_rd(tgd_pkg::OFF_TX_BUF_ADDR, 32'h89AB_CDEF, 32'h89AB_CDEF);
        wr_rd(tgd_pkg::OFF_TX_BUF_COUNT, 32'hFFFF_8001, 32'h0000_8001);
        $display("done: registers");
        // idle time-out: off at zero, then limit 2 is eight bit periods
        apb(1'b1, tgd_pkg::OFF_RX_IDLE_LIMIT, 32'h0000_0000);
        model_u.rx_char();
        model_u.ticks(12);
        `CHK("timeout off", 1'b0, rx_timeout)
        apb(1'b1, tgd_pkg::OFF_RX_IDLE_LIMIT, 32'h0000_0002);
        model_u.ticks(10);
        `CHK("timeout before rx", 1'b0, rx_timeout)
        model_u.rx_char();
        model_u.ticks(7);
        cyc(3);
        `CHK("timeout early", 1'b0, rx_timeout)
        model_u.rx_char();
        model_u.ticks(7);
        cyc(3);
        `CHK("timeout reload", 1'b0, rx_timeout)
        model_u.ticks(1);
        cyc(3);
        `CHK("timeout expiry", 1'b1, rx_timeout)
        model_u.rx_char();
        model_u.ticks(9);
        `CHK("timeout held", 1'b1, rx_timeout)
        apb(1'b1, tgd_pkg::OFF_RX_IDLE_LIMIT, 32'h0000_0002);
        `CHK("write restarts", 1'b0, rx_timeout)
        model_u.rx_char();
        model_u.ticks(8);
        cyc(3);
        `CHK("timeout again", 1'b1, rx_timeout)
        apb(1'b1, tgd_pkg::OFF_CONTROL, 32'h0000_0001);
        `CHK("start command", 1'b0, rx_timeout)
        $display("done: time-out");
        // guard gap: none at zero, three bit periods at three
        apb(1'b1, tgd_pkg::OFF_TX_GAP, 32'h0000_0000);
        model_u.tx_char();
        `CHK("no guard", 1'b0, tx_hold_off)
        apb(1'b1, tgd_pkg::OFF_TX_GAP, 32'h0000_0003);
        model_u.tx_char();
        `CHK("guard on", 1'b1, tx_hold_off)
        `CHK("line high", 1'b1, txd)
        model_u.ticks(2);
        cyc(3);
        `CHK("guard running", 1'b1, tx_hold_off)
        model_u.ticks(1);
        cyc(3);
        `CHK("guard over", 1'b0, tx_hold_off)
        $display("done: guard");
        // receive channel: two characters, then stopped at zero
        pulse(2);
        `CHK("rx read clears", 1'b0, rx_char_available)
        apb(1'b1, tgd_pkg::OFF_RX_BUF_ADDR, 32'h2000_00FE);
        apb(1'b1, tgd_pkg::OFF_RX_BUF_COUNT, 32'h0000_0002);
        `CHK("rx req idle", 1'b0, rx_xfer_req)
        model_u.rx_char();
        `CHK("rx available", 1'b1, rx_char_available)
        `CHK("rx req", 1'b1, rx_xfer_req)
        pulse(0);
        `CHK("rx addr step", 32'h2000_00FF, rx_xfer_addr)
        apb(1'b0, tgd_pkg::OFF_RX_BUF_COUNT, 32'h0000_0000);
        `CHK("rx count step", 32'h0000_0001, rd)
        pulse(0);
        pulse(0);
        `CHK("rx addr stop", 32'h2000_0100, rx_xfer_addr)
        `CHK("rx req stop", 1'b0, rx_xfer_req)
        // transmit channel: free condition, break and full holding
        apb(1'b1, tgd_pkg::OFF_TX_BUF_COUNT, 32'h0000_0000);
        `CHK("tx req stop", 1'b0, tx_xfer_req)
        `CHK("tx free", 1'b1, tx_holding_free)
        apb(1'b1, tgd_pkg::OFF_TX_BUF_ADDR, 32'hFFFF_FFFF);
        apb(1'b1, tgd_pkg::OFF_TX_BUF_COUNT, 32'h0000_0001);
        `CHK("tx req", 1'b1, tx_xfer_req)
        break_pending <= 1'b1;
        cyc(1);
        `CHK("tx free break", 1'b0, tx_holding_free)
        `CHK("tx req break", 1'b0, tx_xfer_req)
        {break_pending, holding_empty} <= 2'h0;
        cyc(1);
        `CHK("tx free full", 1'b0, tx_holding_free)
        holding_empty <= 1'b1;
        pulse(1);
        `CHK("tx addr step", 32'h0000_0000, tx_xfer_addr)
        `CHK("tx req done", 1'b0, tx_xfer_req)
        // status word: character still waiting, holding free, all else idle
        apb(1'b0, tgd_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK("status word", 32'h0000_0006, rd)
        $display("done: channels");
        results();
    end
endmodule : usart_timeout_guard_dma_regs_tb
